// >>> hw/dtx_pkg.sv
//------------------------------------------------------------------------------
// dtx_pkg: constants for the tone transceiver host pin logic
//------------------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and cycle counts
// Assumes: 125 MHz system clock
// Notes:   status word layout and burst timing are local choices
//------------------------------------------------------------------------------
package dtx_pkg;

	// clock and timing
	localparam int unsigned CLK_NS       = 8;
	localparam int unsigned SETTLE_NS    = 40;
	localparam int unsigned SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BURST_MS     = 50;
	localparam int unsigned BURST_CYC    = BURST_MS * 1000000 / CLK_NS;
	localparam int unsigned CNT_W        = 23;
	localparam int unsigned SET_W        = 3;

	// register select values
	localparam logic        RSEL_DATA    = 1'h0;
	localparam logic        RSEL_STAT    = 1'h1;

	// status word bit positions
	localparam int unsigned ST_IRQ       = 0;
	localparam int unsigned ST_TXDONE    = 1;
	localparam int unsigned ST_DSTEER    = 2;
	localparam int unsigned ST_EARLY     = 3;

	// reset values
	localparam logic [3:0]  CODE_RST     = 4'h0;

	// burst sequencer states
	typedef enum logic [2:0] {
		BS_IDLE = 3'b001,
		BS_TONE = 3'b010,
		BS_GAP  = 3'b100
	} dtx_bstate_type;

endpackage

// >>> hw/dtx_burst.sv
//------------------------------------------------------------------------------
// dtx_burst: tone burst and pause timer
//------------------------------------------------------------------------------
// Purpose: time a tone burst followed by an equal pause, or follow a level
// Assumes: start is a one-cycle pulse
// Notes:   a start during a burst is ignored until the pause has ended
//------------------------------------------------------------------------------
`timescale 1ns/1ns
module dtx_burst import dtx_pkg::*; #(
	parameter int unsigned BURST_LEN = BURST_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic sleep,
	input  wire logic burst_mode,
	input  wire logic start,
	input  wire logic level_on,
	// status
	output logic      tone_on,
	output logic      done
);

	typedef struct packed {
		dtx_bstate_type   st;
		logic [CNT_W-1:0] cnt;
		logic             done;
	} dtx_burst_type;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(BURST_LEN - 1);

	dtx_burst_type q, d;

	// sequencer: burst then pause, each counted out in cycles
	always_comb begin
		d      = q;
		d.done = 1'b0;
		case (q.st)
			BS_IDLE: begin
				if (start && burst_mode && !sleep) begin
					d.st  = BS_TONE;
					d.cnt = '0;
				end
			end
			BS_TONE: begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == LAST) begin
					d.st  = BS_GAP;
					d.cnt = '0;
				end
			end
			BS_GAP: begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == LAST) begin
					d.st   = BS_IDLE;
					d.done = 1'b1;
				end
			end
			default: d.st = BS_IDLE;
		endcase
		// sleeping transmitter drops any burst in flight
		if (sleep) begin
			d.st  = BS_IDLE;
			d.cnt = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '{st: BS_IDLE, cnt: '0, done: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign tone_on = (q.st == BS_TONE) || (!burst_mode && level_on && !sleep);
	assign done    = q.done;

	// done only after a full pause
	burst_done_a: assert property (@(posedge clk) disable iff (rst)
		done |-> $past(q.st == BS_GAP) && $past(q.cnt) == LAST)
		else $error("burst done without full pause");

	// the burst runs its full length
	burst_len_a: assert property (@(posedge clk) disable iff (rst)
		(q.st == BS_TONE && q.cnt != LAST && !sleep) |=> q.st == BS_TONE)
		else $error("burst cut short");

endmodule

// >>> hw/dtx_host_pins.sv
//------------------------------------------------------------------------------
// dtx_host_pins: host bus, steering and interrupt pin logic
//------------------------------------------------------------------------------
// Purpose: 4-bit host port, steering handshake, shared interrupt pin
// Assumes: all inputs synchronous to CLK; steering level already compared
// Notes:   read data lags the strobe by one clock; status read clears irq
//------------------------------------------------------------------------------
`timescale 1ns/1ns
module dtx_host_pins import dtx_pkg::*; #(
	parameter int unsigned BURST_LEN = BURST_CYC
) (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// host bus
	input  wire logic       BUS_STROBE_STYLE,
	input  wire logic       CHIP_SELECT_N,
	input  wire logic       DIRECTION,
	input  wire logic       REGISTER_SELECT_LINE,
	input  wire logic       TRANSFER_STROBE,
	input  wire logic [3:0] HOST_DATA_LINES_IN,
	output logic      [3:0] HOST_DATA_LINES_OUT,
	output logic            HOST_DATA_LINES_OE,
	output logic            HOST_WRITE,
	output logic      [3:0] HOST_WRITE_DATA,
	// control bits
	input  wire logic       POWERDOWN_PIN,
	input  wire logic       RECEIVER_SLEEP_BIT,
	input  wire logic       TRANSMITTER_SLEEP_BIT,
	input  wire logic       IRQ_MODE,
	input  wire logic       BURST_MODE,
	input  wire logic       TX_START,
	input  wire logic       TX_LEVEL,
	// receiver
	input  wire logic       PAIR_VALID,
	input  wire logic [3:0] PAIR_CODE,
	input  wire logic       PROGRESS_IN,
	output logic            EARLY_PAIR_DETECT,
	input  wire logic       STEER_GUARD_PIN_IN,
	output logic            STEER_GUARD_PIN_OUT,
	output logic            STEER_GUARD_PIN_OE,
	output logic            DELAYED_STEER,
	// interrupt pin, open drain
	output logic            INTERRUPT_OR_PROGRESS_OUT,
	output logic            INTERRUPT_OR_PROGRESS_OE,
	// transmitter
	output logic            TONE_OE,
	output logic            TONE_ON,
	output logic            OSC_RUN
);

	typedef struct packed {
		logic             early_pair_detect;
		logic             st_prev;
		logic             dst;
		logic [SET_W-1:0] settle;
		logic             settling;
		logic [3:0]       code;
		logic             irq;
		logic             rd_prev;
		logic             wr_prev;
		logic [3:0]       dout;
		logic             txdone;
	} dtx_host_type;

	localparam dtx_host_type RST_VAL = '{early_pair_detect: 1'b0, st_prev: 1'b0, dst: 1'b0,
		settle: '0, settling: 1'b0, code: CODE_RST, irq: 1'b0, rd_prev: 1'b0,
		wr_prev: 1'b0, dout: CODE_RST, txdone: 1'b0};

	dtx_host_type q, d;
	logic         full_off;
	logic         rx_off;
	logic         tx_off;
	logic         rd_act;
	logic         wr_act;
	logic         tx_done;
	logic         tone_raw;
	logic [3:0]   stat;

	//--------------------------------------------------------------------------
	// power and bus decode
	//--------------------------------------------------------------------------

	// pin power-down or both sleep bits shut the whole device
	assign full_off = POWERDOWN_PIN || (RECEIVER_SLEEP_BIT && TRANSMITTER_SLEEP_BIT);
	assign rx_off   = full_off || RECEIVER_SLEEP_BIT;
	assign tx_off   = full_off || TRANSMITTER_SLEEP_BIT;
	assign OSC_RUN  = !full_off;

	// strobe style: direction is read/write; split style: it is write strobe
	always_comb begin
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (!CHIP_SELECT_N) begin
			if (BUS_STROBE_STYLE) begin
				rd_act = TRANSFER_STROBE && DIRECTION;
				wr_act = TRANSFER_STROBE && !DIRECTION;
			end else begin
				rd_act = !TRANSFER_STROBE;
				wr_act = !DIRECTION;
			end
		end
	end

	// status word seen on a status read
	always_comb begin
		stat            = 4'h0;
		stat[ST_IRQ]    = q.irq;
		stat[ST_TXDONE] = q.txdone;
		stat[ST_DSTEER] = q.dst;
		stat[ST_EARLY]  = q.early_pair_detect;
	end

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------

	always_comb begin
		d         = q;
		d.rd_prev = rd_act;
		d.wr_prev = wr_act;
		// early detect follows the detector with no hold-over
		d.early_pair_detect     = PAIR_VALID && !rx_off;
		d.st_prev = STEER_GUARD_PIN_IN;
		// steering rise registers the pair and starts the settle delay
		if (STEER_GUARD_PIN_IN && !q.st_prev && !rx_off) begin
			d.code     = PAIR_CODE;
			d.settling = 1'b1;
			d.settle   = '0;
		end else if (q.settling) begin
			d.settle = q.settle + 1'b1;
			if (q.settle == SET_W'(SETTLE_CYC - 1)) begin
				d.settling = 1'b0;
				d.dst      = 1'b1;
			end
		end
		// steering low frees the receiver for the next pair
		if (!STEER_GUARD_PIN_IN) begin
			d.dst      = 1'b0;
			d.settling = 1'b0;
		end
		// register selected by the single select line
		d.dout = (REGISTER_SELECT_LINE == RSEL_DATA) ? q.code : stat;
		// status read end clears the sticky flags; a new event wins
		if (q.rd_prev && !rd_act && REGISTER_SELECT_LINE == RSEL_STAT) begin
			d.irq    = 1'b0;
			d.txdone = 1'b0;
		end
		if (tx_done) begin
			d.irq    = 1'b1;
			d.txdone = 1'b1;
		end
		if (d.dst && !q.dst) begin
			d.irq = 1'b1;
		end
		if (rx_off) begin
			d.dst      = 1'b0;
			d.settling = 1'b0;
		end
		// power-down acts like a reset of all control state
		if (full_off) begin
			d = RST_VAL;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= RST_VAL;
		end else begin
			q <= d;
		end
	end

	//--------------------------------------------------------------------------
	// transmitter burst timer
	//--------------------------------------------------------------------------

	dtx_burst #(
		.BURST_LEN (BURST_LEN)
	) u_burst (
		.clk        (CLK),
		.rst        (RST),
		.sleep      (tx_off),
		.burst_mode (BURST_MODE),
		.start      (TX_START),
		.level_on   (TX_LEVEL),
		.tone_on    (tone_raw),
		.done       (tx_done)
	);

	//--------------------------------------------------------------------------
	// pins
	//--------------------------------------------------------------------------

	// data drive only inside a read access of a powered device
	assign HOST_DATA_LINES_OE  = rd_act && !full_off;
	assign HOST_DATA_LINES_OUT = q.dout;
	// write strobe edge passes the nibble to the register side
	assign HOST_WRITE          = wr_act && !q.wr_prev && !full_off;
	assign HOST_WRITE_DATA     = HOST_DATA_LINES_IN;

	assign EARLY_PAIR_DETECT   = q.early_pair_detect;
	assign DELAYED_STEER       = q.dst;
	// guard drives only when early detect and steering agree, else floats
	assign STEER_GUARD_PIN_OUT = q.early_pair_detect;
	assign STEER_GUARD_PIN_OE  = (q.early_pair_detect == STEER_GUARD_PIN_IN) && !rx_off;

	// open drain: enable means pulling low
	assign INTERRUPT_OR_PROGRESS_OUT = 1'b0;
	// in interrupt mode the pin stays low while delayed steering stands, even once the flag is read
	assign INTERRUPT_OR_PROGRESS_OE  = !full_off &&
		(IRQ_MODE ? (q.irq || q.dst) : (!PROGRESS_IN && !rx_off));

	assign TONE_OE = !tx_off;
	assign TONE_ON = tone_raw && !tx_off;

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------

	data_float_a: assert property (@(posedge CLK) disable iff (RST)
		(CHIP_SELECT_N || (BUS_STROBE_STYLE && !TRANSFER_STROBE) ||
		 (!BUS_STROBE_STYLE && TRANSFER_STROBE)) |-> !HOST_DATA_LINES_OE)
		else $error("data lines driven outside a read");

	pd_float_a: assert property (@(posedge CLK) disable iff (RST)
		POWERDOWN_PIN |-> !HOST_DATA_LINES_OE && !INTERRUPT_OR_PROGRESS_OE &&
		!TONE_OE && !OSC_RUN)
		else $error("pins not floated in power-down");

	early_follow_a: assert property (@(posedge CLK) disable iff (RST)
		(PAIR_VALID && !rx_off) ##1 !PAIR_VALID |=> !EARLY_PAIR_DETECT)
		else $error("early detect held after loss");

	steer_latch_a: assert property (@(posedge CLK) disable iff (RST)
		($rose(STEER_GUARD_PIN_IN) && !rx_off) |=> q.code == $past(PAIR_CODE))
		else $error("code not latched on steering rise");

	settle_delay_a: assert property (@(posedge CLK) disable iff (RST)
		($rose(STEER_GUARD_PIN_IN) && !rx_off) ##1 (STEER_GUARD_PIN_IN && !rx_off)[*5]
		|=> DELAYED_STEER)
		else $error("delayed steering not raised after settle");

	steer_free_a: assert property (@(posedge CLK) disable iff (RST)
		!STEER_GUARD_PIN_IN |=> !DELAYED_STEER)
		else $error("delayed steering held with steering low");

	irq_pull_a: assert property (@(posedge CLK) disable iff (RST)
		($rose(DELAYED_STEER) && IRQ_MODE && !full_off) |-> INTERRUPT_OR_PROGRESS_OE)
		else $error("no interrupt on registration");

	progress_a: assert property (@(posedge CLK) disable iff (RST)
		(!IRQ_MODE && !full_off && !RECEIVER_SLEEP_BIT) |->
		INTERRUPT_OR_PROGRESS_OE == !PROGRESS_IN)
		else $error("progress output not following input");

	tx_float_a: assert property (@(posedge CLK) disable iff (RST)
		TRANSMITTER_SLEEP_BIT |-> !TONE_OE && !TONE_ON)
		else $error("transmit output driven while asleep");

	read_data_a: assert property (@(posedge CLK) disable iff (RST)
		(rd_act && $past(rd_act) && REGISTER_SELECT_LINE == RSEL_DATA &&
		 $stable(REGISTER_SELECT_LINE) && !full_off && !$past(full_off)) |->
		HOST_DATA_LINES_OUT == $past(q.code))
		else $error("wrong receive data on read");

endmodule

// >>> verification/dtx_host_model.sv
//------------------------------------------------------------------------------
// Purpose: host processor model on the 4-bit bus
// Assumes: tasks are entered 1 ns after a rising edge
// Notes:   an undriven bus shows the inverse of its last level, never a stale copy
//------------------------------------------------------------------------------
`timescale 1ns/1ns
module dtx_host_model import dtx_pkg::*; (
	// clock and bus style
	input  wire logic       clk,
	input  wire logic       strobe_style,
	// bus pins driven by the host
	output logic            cs_n,
	output logic            dir,
	output logic            rsel,
	output logic            strobe,
	output logic      [3:0] bus_level,
	// device side of the bus
	input  wire logic [3:0] dev_data,
	input  wire logic       dev_oe,
	input  wire logic       dev_wr,
	input  wire logic [3:0] dev_wdata
);
	logic       host_drv;
	logic [3:0] host_val;
	logic [3:0] last_q = 4'h0;

	// resolved data lines; a floating bus toggles so it cannot pass for data
	always_comb begin
		if (dev_oe)
			bus_level = dev_data;
		else if (host_drv)
			bus_level = host_val;
		else
			bus_level = ~last_q;
	end
	always @(posedge clk)
		last_q <= bus_level;

	// power-up state: bus released, strobe-style idle
	initial begin
		cs_n     = 1'h1;
		dir      = 1'h1;
		rsel     = 1'h0;
		strobe   = 1'h0;
		host_drv = 1'h0;
		host_val = 4'h0;
	end

	// release: chip select only during a cycle, strobe idle for the style
	task automatic idle();
		cs_n     = 1'h1;
		dir      = 1'h1;
		strobe   = ~strobe_style;
		host_drv = 1'h0;
	endtask

	// read cycle held over two edges, since read data lags by one clock
	task automatic rd(input logic rs, output logic [3:0] val, output logic oe);
		cs_n   = 1'h0;
		rsel   = rs;
		dir    = 1'h1;
		strobe = strobe_style;
		@(posedge clk);
		@(posedge clk);
		#1;
		val = bus_level;
		oe  = dev_oe;
		idle();
	endtask

	// write cycle; strobe high is data strobe active or read line idle
	task automatic wr(input logic rs, input logic [3:0] v, output logic [1:0] pulse,
		output logic [3:0] seen);
		cs_n     = 1'h0;
		rsel     = rs;
		host_val = v;
		host_drv = 1'h1;
		dir      = 1'h0;
		strobe   = 1'h1;
		#1;
		pulse[1] = dev_wr;
		seen     = dev_wdata;
		@(posedge clk);
		#1;
		pulse[0] = dev_wr;
		idle();
	endtask
endmodule

// >>> verification/tb.sv
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the host pin logic
// Assumes: inputs change 1 ns after a rising edge
// Notes:   burst length cut to 8 cycles so the run stays short
//------------------------------------------------------------------------------
`timescale 1ns/1ns
module tb import dtx_pkg::*;;
	localparam int unsigned BL = 8;
	logic       clk = 1'h0, rst = 1'h1, style = 1'h1, pd = 1'h0, rxs = 1'h0, txs = 1'h0;
	logic       irqm = 1'h1, bm = 1'h0, txst = 1'h0, txl = 1'h0, pv = 1'h0, prog = 1'h1;
	logic       sin = 1'h0;
	logic       cs_n, dir, rsel, stb, doe, hwr, early, sw, sout, soe, dst, irq, irqoe;
	logic       toe, ton, osc, o;
	logic [3:0] din, dout, hwd, v;
	logic [3:0] pc = 4'h0;
	logic [1:0] p;
	int         n, n_errors = 0, checked = 0, cyc = 0;

	// node level is the bench's: the guard drives only when it agrees with the node,
	// so feeding it back adds nothing but a combinational loop that would latch it
	assign sw = sin;

	dtx_host_pins #(.BURST_LEN(BL)) i_dut (
		.CLK(clk), .RST(rst), .BUS_STROBE_STYLE(style), .CHIP_SELECT_N(cs_n),
		.DIRECTION(dir), .REGISTER_SELECT_LINE(rsel), .TRANSFER_STROBE(stb),
		.HOST_DATA_LINES_IN(din), .HOST_DATA_LINES_OUT(dout), .HOST_DATA_LINES_OE(doe),
		.HOST_WRITE(hwr), .HOST_WRITE_DATA(hwd), .POWERDOWN_PIN(pd),
		.RECEIVER_SLEEP_BIT(rxs), .TRANSMITTER_SLEEP_BIT(txs), .IRQ_MODE(irqm),
		.BURST_MODE(bm), .TX_START(txst), .TX_LEVEL(txl), .PAIR_VALID(pv),
		.PAIR_CODE(pc), .PROGRESS_IN(prog), .EARLY_PAIR_DETECT(early),
		.STEER_GUARD_PIN_IN(sw), .STEER_GUARD_PIN_OUT(sout), .STEER_GUARD_PIN_OE(soe),
		.DELAYED_STEER(dst), .INTERRUPT_OR_PROGRESS_OUT(irq),
		.INTERRUPT_OR_PROGRESS_OE(irqoe), .TONE_OE(toe), .TONE_ON(ton), .OSC_RUN(osc));
	dtx_host_model i_host (.clk(clk), .strobe_style(style), .cs_n(cs_n), .dir(dir),
		.rsel(rsel), .strobe(stb), .bus_level(din), .dev_data(dout), .dev_oe(doe),
		.dev_wr(hwr), .dev_wdata(hwd));

	// stands in for the external clock on the oscillator input
	always #4 clk = ~clk;

	// hang guard, far above the roughly 120 cycles the scenarios need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// present a pair, raise the steering level, wait for registration
	task automatic recv(input logic [3:0] code);
		pv = 1'h1;
		pc = code;
		tick(1);
		chk(early, 1'h1);
		chk(soe, 1'h0);
		sin = 1'h1;
		for (n = 1; n < 15; n++) begin
			tick(1);
			if (dst === 1'h1)
				break;
		end
		chk(n[3:0], 4'(SETTLE_CYC + 1));
		chk(sout, 1'h1);
		chk(soe, 1'h1);
	endtask

	// code held while a new one is offered; early drop alone keeps the flag
	task automatic t_receive();
		recv(4'hB);
		chk(irqoe, 1'h1);
		pc = 4'h3;
		i_host.rd(RSEL_DATA, v, o);
		chk(v, 4'hB);
		chk(o, 1'h1);
		tick(1);
		chk(doe, 1'h0);
		i_host.rd(RSEL_STAT, v, o);
		chk(v, 4'hD);
		pv = 1'h0;
		tick(1);
		chk(early, 1'h0);
		chk(dst, 1'h1);
		chk(irqoe, 1'h1);
		sin = 1'h0;
		tick(2);
		chk(dst, 1'h0);
		recv(4'h5);
		i_host.rd(RSEL_DATA, v, o);
		chk(v, 4'h5);
		pv = 1'h0;
		sin = 1'h0;
		tick(2);
	endtask

	// both bus styles: write pulse one cycle, split-style read
	task automatic t_styles();
		i_host.wr(RSEL_STAT, 4'hA, p, v);
		chk(p, 2'h2);
		chk(v, 4'hA);
		tick(1);
		style = 1'h0;
		i_host.idle();
		tick(1);
		i_host.wr(RSEL_DATA, 4'h6, p, v);
		chk(p, 2'h2);
		chk(v, 4'h6);
		tick(1);
		i_host.rd(RSEL_DATA, v, o);
		chk(v, 4'h5);
		chk(o, 1'h1);
		tick(1);
		chk(doe, 1'h0);
		style = 1'h1;
		i_host.idle();
		tick(1);
	endtask

	// sleep bits one at a time and together, then the power-down pin
	task automatic t_power();
		txs = 1'h1;
		tick(1);
		chk(toe, 1'h0);
		chk(osc, 1'h1);
		i_host.rd(RSEL_DATA, v, o);
		chk(o, 1'h1);
		tick(1);
		rxs = 1'h1;
		tick(1);
		chk(osc, 1'h0);
		i_host.rd(RSEL_DATA, v, o);
		chk(o, 1'h0);
		tick(1);
		rxs = 1'h0;
		txs = 1'h0;
		tick(1);
		chk(toe, 1'h1);
		// receiver asleep alone: no early detect, oscillator still runs
		rxs = 1'h1;
		pv = 1'h1;
		tick(2);
		chk(early, 1'h0);
		chk(osc, 1'h1);
		rxs = 1'h0;
		pv = 1'h0;
		tick(1);
		recv(4'h7);
		chk(irqoe, 1'h1);
		pd = 1'h1;
		tick(1);
		chk(irqoe, 1'h0);
		chk(toe, 1'h0);
		chk(osc, 1'h0);
		chk(early, 1'h0);
		i_host.rd(RSEL_STAT, v, o);
		chk(o, 1'h0);
		tick(1);
		pd = 1'h0;
		pv = 1'h0;
		sin = 1'h0;
		tick(2);
	endtask

	// timed burst: tone length, pause, then interrupt cleared by status read
	task automatic t_burst();
		bm = 1'h1;
		txst = 1'h1;
		tick(1);
		txst = 1'h0;
		n = 0;
		// sample from the first tone cycle on
		repeat (4 * BL) begin
			if (ton === 1'h1)
				n++;
			tick(1);
		end
		chk(n[3:0], 4'(BL));
		chk(irqoe, 1'h1);
		i_host.rd(RSEL_STAT, v, o);
		chk(v, 4'h3);
		tick(1);
		chk(irqoe, 1'h0);
		bm = 1'h0;
		txl = 1'h1;
		tick(2);
		chk(ton, 1'h1);
		txl = 1'h0;
		tick(1);
	endtask

	// call-progress mode: pin follows the in-band square wave
	task automatic t_progress();
		irqm = 1'h0;
		for (int i = 0; i < 4; i++) begin
			prog = i[0];
			tick(2);
			chk(irqoe, !prog);
		end
		irqm = 1'h1;
		tick(1);
	endtask

	// reset, idle checks, then every scenario in turn
	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'h0;
		tick(1);
		chk(early, 1'h0);
		chk(dst, 1'h0);
		chk(irqoe, 1'h0);
		chk(irq, 1'h0);
		chk(doe, 1'h0);
		t_receive();
		t_styles();
		t_power();
		t_burst();
		t_progress();
		tally_and_finish();
	end
endmodule
